//--- cise_pkg.sv
// Package with constants and types for the instruction subset executor.
package cise_pkg;

    // ==========================================================================
    // Widths
    // ==========================================================================
    localparam int FILE_ADDR_W = 7;
    localparam int DATA_W      = 8;
    localparam int LIT_W       = 11;
    localparam int PC_W        = 13;
    localparam int LATCH_W     = 5;
    localparam int REG_ADDR_W  = 2;

    // ==========================================================================
    // Values after reset and fixed values
    // ==========================================================================
    localparam logic [DATA_W-1:0] DATA_ZERO      = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ONE       = 8'h01;
    localparam logic [PC_W-1:0]   PC_RESET       = 13'h0000;
    localparam logic              NULL_RESET     = 1'h0;
    localparam logic              EXPIRY_RESET   = 1'h1;
    localparam logic              SLEEP_RESET    = 1'h1;
    localparam logic              ENABLE_RESET   = 1'h1;
    localparam logic              DEST_ACCUM     = 1'h0;
    localparam logic              DEST_FILE      = 1'h1;

    // ==========================================================================
    // Field positions
    // ==========================================================================
    localparam int LATCH_HI_BIT   = 4;
    localparam int LATCH_LO_BIT   = 3;
    localparam int CTRL_EN_BIT    = 0;
    localparam int STAT_NULL_BIT  = 0;
    localparam int STAT_EXP_BIT   = 1;
    localparam int STAT_SLEEP_BIT = 2;
    localparam int STAT_DISC_BIT  = 3;

    // ==========================================================================
    // Register indices on the plain register port
    // ==========================================================================
    localparam logic [REG_ADDR_W-1:0] REG_CTRL   = 2'h0;
    localparam logic [REG_ADDR_W-1:0] REG_STATUS = 2'h1;
    localparam logic [REG_ADDR_W-1:0] REG_ACCUM  = 2'h2;

    // ==========================================================================
    // Operation codes
    // ==========================================================================
    typedef enum logic [3:0] {
        OP_NOP                    = 4'h0,
        OP_WATCHDOG_KICK          = 4'h1,
        OP_INVERT_FILE            = 4'h2,
        OP_CLEAR_FILE             = 4'h3,
        OP_DECREMENT_FILE         = 4'h4,
        OP_CLEAR_ACCUMULATOR      = 4'h5,
        OP_DECREMENT_SKIP_IF_NULL = 4'h6,
        OP_JUMP_ABSOLUTE          = 4'h7
    } cise_op_t;

    // ==========================================================================
    // Pipeline states
    // ==========================================================================
    typedef enum logic [1:0] {
        ST_EXEC  = 2'h1,
        ST_FLUSH = 2'h2
    } cise_state_t;

    // ==========================================================================
    // Carriers
    // ==========================================================================
    typedef struct packed {
        logic                   valid;
        cise_op_t               op;
        logic [FILE_ADDR_W-1:0] fileAddr;
        logic                   dest;
        logic [LIT_W-1:0]       literal;
    } cise_instr_t;

    typedef struct packed {
        logic                   en;
        logic [FILE_ADDR_W-1:0] addr;
        logic [DATA_W-1:0]      data;
    } cise_file_wr_t;

endpackage : cise_pkg

//--- cise_exec_core.sv
// Execution unit for the watchdog, clear, complement, decrement and jump instructions.
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps

// Notes on behaviour
// - Watchdog kick zeroes the watchdog counter and its prescaler; no operands.
// - Watchdog kick sets the expiry flag and the sleep-entry flag to one.
// - File operands are 7-bit addresses; destination 0 is accumulator, 1 is file.
// - Invert-file complements the file register to destination and updates null flag.
// - Clear-file writes 00h to the file register and sets the null flag.
// - Clear-accumulator loads 00h into the accumulator and sets the null flag.
// - Decrement-file subtracts one to destination and updates the null flag.
// - Decrement-skip subtracts one, keeps flags, and on zero discards the next instruction.
// - Jump loads literal into PC bits 10:0 and latch bits 4:3 into 12:11.
// - Jump takes two cycles because the next fetched instruction is flushed.
module cise_exec_core (
    // Clock and reset
    input  wire logic                              clock,
    input  wire logic                              rst,
    // Instruction from the fetch stage
    input  wire cise_pkg::cise_instr_t             instrIn,
    // File register read data for instrIn.fileAddr
    input  wire logic [cise_pkg::DATA_W-1:0]       fileRdData,
    // Upper jump latch and status events
    input  wire logic [cise_pkg::LATCH_W-1:0]      upperJumpLatch,
    input  wire logic                              watchdogTimeout,
    input  wire logic                              sleepEnter,
    // Register port
    input  wire logic [cise_pkg::REG_ADDR_W-1:0]   regAddr,
    input  wire logic [cise_pkg::DATA_W-1:0]       regWrData,
    input  wire logic                              regWr,
    input  wire logic                              regRd,
    output logic      [cise_pkg::DATA_W-1:0]       regRdData,
    // Datapath results
    output cise_pkg::cise_file_wr_t                fileWr,
    output logic      [cise_pkg::DATA_W-1:0]       accumulator,
    output logic                                   nullFlag,
    output logic                                   watchdogExpiryFlag,
    output logic                                   sleepEntryFlag,
    output logic                                   watchdogClear,
    // Program counter and fetch control
    output logic                                   pcLoad,
    output logic      [cise_pkg::PC_W-1:0]         pcValue,
    output logic                                   discardNext
);

    // ==========================================================================
    // Decode
    // ==========================================================================
    cise_pkg::cise_state_t       state;
    cise_pkg::cise_state_t       next_state;
    logic                        ctrlEnable;
    logic                        take;
    logic [cise_pkg::DATA_W-1:0] next_result;
    logic                        resultIsNull;
    logic                        skipTaken;
    logic                        flushReq;

    assign take = instrIn.valid && (state == cise_pkg::ST_EXEC) && ctrlEnable;

    always_comb begin
        case (instrIn.op)
            cise_pkg::OP_INVERT_FILE:            next_result = ~fileRdData;
            cise_pkg::OP_DECREMENT_FILE:         next_result = fileRdData - cise_pkg::DATA_ONE;
            cise_pkg::OP_DECREMENT_SKIP_IF_NULL: next_result = fileRdData - cise_pkg::DATA_ONE;
            default:                             next_result = cise_pkg::DATA_ZERO;
        endcase
    end

    assign resultIsNull = (next_result == cise_pkg::DATA_ZERO);
    assign skipTaken    = take && (instrIn.op == cise_pkg::OP_DECREMENT_SKIP_IF_NULL)
                          && resultIsNull;
    assign flushReq     = skipTaken || (take && (instrIn.op == cise_pkg::OP_JUMP_ABSOLUTE));

    // ==========================================================================
    // Pipeline state
    // ==========================================================================
    always_comb begin
        case (state)
            cise_pkg::ST_EXEC:  next_state = flushReq ? cise_pkg::ST_FLUSH : cise_pkg::ST_EXEC;
            cise_pkg::ST_FLUSH: next_state = cise_pkg::ST_EXEC;
            default:            next_state = cise_pkg::ST_EXEC;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state       <= cise_pkg::ST_EXEC;
            discardNext <= 1'b0;
        end else begin
            state       <= next_state;
            discardNext <= (next_state == cise_pkg::ST_FLUSH);
        end
    end

    // ==========================================================================
    // Accumulator and file write-back
    // ==========================================================================
    always_ff @(posedge clock) begin
        if (rst) begin
            accumulator <= cise_pkg::DATA_ZERO;
        end else if (take) begin
            case (instrIn.op)
                cise_pkg::OP_CLEAR_ACCUMULATOR: begin
                    accumulator <= cise_pkg::DATA_ZERO;
                end
                cise_pkg::OP_INVERT_FILE,
                cise_pkg::OP_DECREMENT_FILE,
                cise_pkg::OP_DECREMENT_SKIP_IF_NULL: begin
                    if (instrIn.dest == cise_pkg::DEST_ACCUM) begin
                        accumulator <= next_result;
                    end
                end
                default: begin
                    accumulator <= accumulator;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            fileWr <= '0;
        end else begin
            fileWr.en   <= 1'b0;
            fileWr.addr <= instrIn.fileAddr;
            fileWr.data <= next_result;
            if (take) begin
                case (instrIn.op)
                    cise_pkg::OP_CLEAR_FILE: begin
                        fileWr.en   <= 1'b1;
                        fileWr.data <= cise_pkg::DATA_ZERO;
                    end
                    cise_pkg::OP_INVERT_FILE,
                    cise_pkg::OP_DECREMENT_FILE,
                    cise_pkg::OP_DECREMENT_SKIP_IF_NULL: begin
                        fileWr.en <= (instrIn.dest == cise_pkg::DEST_FILE);
                    end
                    default: begin
                        fileWr.en <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ==========================================================================
    // Result-null flag
    // ==========================================================================
    always_ff @(posedge clock) begin
        if (rst) begin
            nullFlag <= cise_pkg::NULL_RESET;
        end else if (take) begin
            case (instrIn.op)
                cise_pkg::OP_CLEAR_FILE,
                cise_pkg::OP_CLEAR_ACCUMULATOR: begin
                    nullFlag <= 1'b1;
                end
                cise_pkg::OP_INVERT_FILE,
                cise_pkg::OP_DECREMENT_FILE: begin
                    nullFlag <= resultIsNull;
                end
                default: begin
                    nullFlag <= nullFlag;
                end
            endcase
        end
    end

    // ==========================================================================
    // Watchdog kick and status flags
    // ==========================================================================
    logic kickNow;

    assign kickNow = take && (instrIn.op == cise_pkg::OP_WATCHDOG_KICK);

    always_ff @(posedge clock) begin
        if (rst) begin
            watchdogClear <= 1'b0;
        end else begin
            watchdogClear <= kickNow;
        end
    end

    // A kick in the same cycle as a timeout or sleep event wins.
    always_ff @(posedge clock) begin
        if (rst) begin
            watchdogExpiryFlag <= cise_pkg::EXPIRY_RESET;
            sleepEntryFlag     <= cise_pkg::SLEEP_RESET;
        end else if (kickNow) begin
            watchdogExpiryFlag <= 1'b1;
            sleepEntryFlag     <= 1'b1;
        end else begin
            if (watchdogTimeout) begin
                watchdogExpiryFlag <= 1'b0;
            end
            if (sleepEnter) begin
                sleepEntryFlag <= 1'b0;
            end
        end
    end

    // ==========================================================================
    // Program counter load
    // ==========================================================================
    always_ff @(posedge clock) begin
        if (rst) begin
            pcLoad  <= 1'b0;
            pcValue <= cise_pkg::PC_RESET;
        end else begin
            pcLoad <= take && (instrIn.op == cise_pkg::OP_JUMP_ABSOLUTE);
            if (take && (instrIn.op == cise_pkg::OP_JUMP_ABSOLUTE)) begin
                pcValue <= {upperJumpLatch[cise_pkg::LATCH_HI_BIT:cise_pkg::LATCH_LO_BIT],
                            instrIn.literal};
            end
        end
    end

    // ==========================================================================
    // Register port
    // ==========================================================================
    logic [cise_pkg::DATA_W-1:0] statusWord;

    always_comb begin
        statusWord                          = cise_pkg::DATA_ZERO;
        statusWord[cise_pkg::STAT_NULL_BIT]  = nullFlag;
        statusWord[cise_pkg::STAT_EXP_BIT]   = watchdogExpiryFlag;
        statusWord[cise_pkg::STAT_SLEEP_BIT] = sleepEntryFlag;
        statusWord[cise_pkg::STAT_DISC_BIT]  = discardNext;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrlEnable <= cise_pkg::ENABLE_RESET;
        end else if (regWr && (regAddr == cise_pkg::REG_CTRL)) begin
            ctrlEnable <= regWrData[cise_pkg::CTRL_EN_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            regRdData <= cise_pkg::DATA_ZERO;
        end else if (regRd) begin
            case (regAddr)
                cise_pkg::REG_CTRL: begin
                    regRdData <= {{(cise_pkg::DATA_W-1){1'b0}}, ctrlEnable};
                end
                cise_pkg::REG_STATUS: begin
                    regRdData <= statusWord;
                end
                cise_pkg::REG_ACCUM: begin
                    regRdData <= accumulator;
                end
                default: begin
                    regRdData <= cise_pkg::DATA_ZERO;
                end
            endcase
        end else begin
            regRdData <= cise_pkg::DATA_ZERO;
        end
    end

    // ==========================================================================
    // Assertions
    // ==========================================================================
    a_kick_clears_watchdog: assert property (@(posedge clock) disable iff (rst)
        kickNow |=> watchdogClear ##1 (watchdogClear == $past(kickNow)))
        else $error("Watchdog kick did not give a one-cycle clear.");

    a_kick_sets_flags: assert property (@(posedge clock) disable iff (rst)
        kickNow |=> watchdogExpiryFlag && sleepEntryFlag)
        else $error("Watchdog kick did not set both status flags.");

    a_invert_to_file: assert property (@(posedge clock) disable iff (rst)
        take && instrIn.op == cise_pkg::OP_INVERT_FILE && instrIn.dest
        |=> fileWr.en && fileWr.data == ~$past(fileRdData)
            && fileWr.addr == $past(instrIn.fileAddr))
        else $error("Invert-file write-back is wrong.");

    a_clear_file_write: assert property (@(posedge clock) disable iff (rst)
        take && instrIn.op == cise_pkg::OP_CLEAR_FILE
        |=> fileWr.en && fileWr.data == 8'h00 && nullFlag)
        else $error("Clear-file did not write zero and set the null flag.");

    a_clear_accum: assert property (@(posedge clock) disable iff (rst)
        take && instrIn.op == cise_pkg::OP_CLEAR_ACCUMULATOR
        |=> accumulator == 8'h00 && nullFlag && !fileWr.en)
        else $error("Clear-accumulator result is wrong.");

    a_decrement_accum: assert property (@(posedge clock) disable iff (rst)
        take && instrIn.op == cise_pkg::OP_DECREMENT_FILE && !instrIn.dest
        |=> accumulator == $past(fileRdData) - 8'h01 && !fileWr.en)
        else $error("Decrement to accumulator is wrong.");

    a_null_tracks_result: assert property (@(posedge clock) disable iff (rst)
        take && (instrIn.op == cise_pkg::OP_INVERT_FILE
                 || instrIn.op == cise_pkg::OP_DECREMENT_FILE)
        |=> nullFlag == ($past(fileRdData) == (($past(instrIn.op) == cise_pkg::OP_INVERT_FILE)
                                               ? 8'hFF : 8'h01)))
        else $error("Null flag does not follow the result.");

    a_skip_keeps_flags: assert property (@(posedge clock) disable iff (rst)
        take && instrIn.op == cise_pkg::OP_DECREMENT_SKIP_IF_NULL
        |=> nullFlag == $past(nullFlag) && discardNext == ($past(fileRdData) == 8'h01))
        else $error("Decrement-skip changed a flag or skipped wrongly.");

    a_jump_loads_pc: assert property (@(posedge clock) disable iff (rst)
        take && instrIn.op == cise_pkg::OP_JUMP_ABSOLUTE
        |=> pcLoad && pcValue == {$past(upperJumpLatch[4:3]), $past(instrIn.literal)})
        else $error("Jump loaded the wrong program counter.");

    a_jump_flushes_one: assert property (@(posedge clock) disable iff (rst)
        take && instrIn.op == cise_pkg::OP_JUMP_ABSOLUTE
        |=> discardNext ##1 !discardNext && !pcLoad)
        else $error("Jump did not discard exactly one instruction.");

    c_jump_taken: cover property (@(posedge clock) disable iff (rst)
        take && instrIn.op == cise_pkg::OP_JUMP_ABSOLUTE);

    c_skip_taken: cover property (@(posedge clock) disable iff (rst)
        skipTaken ##1 discardNext && instrIn.valid);

    c_kick_vs_timeout: cover property (@(posedge clock) disable iff (rst)
        kickNow && watchdogTimeout);

endmodule : cise_exec_core

//--- cise_exec_core_tb_top.sv
// Self-checking testbench for the instruction subset execution unit.
`timescale 1ns/1ps

module cise_exec_core_tb_top;

    // ==========================================================================
    // Signals
    // ==========================================================================
    logic                                  clock;
    logic                                  rst;
    cise_pkg::cise_instr_t                 instrIn;
    logic [cise_pkg::DATA_W-1:0]           fileRdData;
    logic [cise_pkg::LATCH_W-1:0]          upperJumpLatch;
    logic                                  watchdogTimeout;
    logic                                  sleepEnter;
    logic [cise_pkg::REG_ADDR_W-1:0]       regAddr;
    logic [cise_pkg::DATA_W-1:0]           regWrData;
    logic                                  regWr;
    logic                                  regRd;
    logic [cise_pkg::DATA_W-1:0]           regRdData;
    cise_pkg::cise_file_wr_t               fileWr;
    logic [cise_pkg::DATA_W-1:0]           accumulator;
    logic                                  nullFlag;
    logic                                  watchdogExpiryFlag;
    logic                                  sleepEntryFlag;
    logic                                  watchdogClear;
    logic                                  pcLoad;
    logic [cise_pkg::PC_W-1:0]             pcValue;
    logic                                  discardNext;
    int                                    miscompares;
    int                                    comparisons;
    logic [cise_pkg::DATA_W-1:0]           rdVal;

    cise_exec_core cise_exec_core_i (
        .clock(clock), .rst(rst), .instrIn(instrIn), .fileRdData(fileRdData),
        .upperJumpLatch(upperJumpLatch), .watchdogTimeout(watchdogTimeout),
        .sleepEnter(sleepEnter), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .fileWr(fileWr), .accumulator(accumulator),
        .nullFlag(nullFlag), .watchdogExpiryFlag(watchdogExpiryFlag),
        .sleepEntryFlag(sleepEntryFlag), .watchdogClear(watchdogClear), .pcLoad(pcLoad),
        .pcValue(pcValue), .discardNext(discardNext)
    );

    always #12.5 clock = ~clock;

    // ==========================================================================
    // Compare tasks and bus tasks
    // ==========================================================================
    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_data

    task automatic chk_pc(input logic [12:0] got, input logic [12:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_pc

    // Presents one instruction; outputs then show the previous instruction's results.
    task automatic step(input cise_pkg::cise_op_t op, input logic [6:0] fa, input logic d,
                        input logic [10:0] lit, input logic [7:0] rd);
        @(posedge clock);
        instrIn <= '{valid: (op != cise_pkg::OP_NOP), op: op, fileAddr: fa, dest: d,
                     literal: lit};
        fileRdData <= rd;
        #1;
    endtask : step

    task automatic reg_write(input logic [1:0] a, input logic [7:0] v);
        @(posedge clock);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge clock);
        regWr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [1:0] a, output logic [7:0] v);
        @(posedge clock);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRd <= 1'b0;
        #1;
        v = regRdData;
    endtask : reg_read

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    // ==========================================================================
    // Scenarios
    // ==========================================================================
    task automatic test_reset;
        chk_bit(watchdogExpiryFlag, 1'b1);
        chk_bit(sleepEntryFlag, 1'b1);
        chk_data(accumulator, 8'h00);
        reg_read(cise_pkg::REG_STATUS, rdVal);
        chk_data(rdVal, 8'h06);
        reg_read(2'h3, rdVal);
        chk_data(rdVal, 8'h00);
    endtask : test_reset

    task automatic test_kick;
        @(posedge clock);
        watchdogTimeout <= 1'b1;
        sleepEnter <= 1'b1;
        @(posedge clock);
        watchdogTimeout <= 1'b0;
        sleepEnter <= 1'b0;
        #1;
        chk_bit(watchdogExpiryFlag, 1'b0);
        step(cise_pkg::OP_WATCHDOG_KICK, 7'h00, 1'b0, 11'h000, 8'h00);
        step(cise_pkg::OP_NOP, 7'h00, 1'b0, 11'h000, 8'h00);
        chk_bit(watchdogClear, 1'b1);
        chk_bit(watchdogExpiryFlag, 1'b1);
        chk_bit(sleepEntryFlag, 1'b1);
        step(cise_pkg::OP_NOP, 7'h00, 1'b0, 11'h000, 8'h00);
        chk_bit(watchdogClear, 1'b0);
        @(posedge clock);
        instrIn         <= '{valid: 1'b1, op: cise_pkg::OP_WATCHDOG_KICK, fileAddr: 7'h00,
                             dest: 1'b0, literal: 11'h000};
        watchdogTimeout <= 1'b1;
        sleepEnter      <= 1'b1;
        @(posedge clock);
        instrIn         <= '0;
        watchdogTimeout <= 1'b0;
        sleepEnter      <= 1'b0;
        #1;
        chk_bit(watchdogClear, 1'b1);
        chk_bit(watchdogExpiryFlag, 1'b1);
        chk_bit(sleepEntryFlag, 1'b1);
    endtask : test_kick

    task automatic test_invert_clear_dec;
        step(cise_pkg::OP_INVERT_FILE, 7'h7F, cise_pkg::DEST_FILE, 11'h000, 8'h5A);
        step(cise_pkg::OP_INVERT_FILE, 7'h00, cise_pkg::DEST_ACCUM, 11'h000, 8'hFF);
        chk_bit(fileWr.en, 1'b1);
        chk_data({1'b0, fileWr.addr}, 8'h7F);
        chk_data(fileWr.data, 8'hA5);
        chk_bit(nullFlag, 1'b0);
        step(cise_pkg::OP_DECREMENT_FILE, 7'h15, cise_pkg::DEST_ACCUM, 11'h000, 8'h00);
        chk_bit(fileWr.en, 1'b0);
        chk_data(accumulator, 8'h00);
        chk_bit(nullFlag, 1'b1);
        step(cise_pkg::OP_CLEAR_FILE, 7'h2A, cise_pkg::DEST_ACCUM, 11'h000, 8'h33);
        chk_data(accumulator, 8'hFF);
        chk_bit(nullFlag, 1'b0);
        step(cise_pkg::OP_DECREMENT_FILE, 7'h01, cise_pkg::DEST_FILE, 11'h000, 8'h80);
        chk_bit(fileWr.en, 1'b1);
        chk_data(fileWr.data, 8'h00);
        chk_bit(nullFlag, 1'b1);
        step(cise_pkg::OP_CLEAR_ACCUMULATOR, 7'h00, 1'b0, 11'h000, 8'h00);
        chk_data(fileWr.data, 8'h7F);
        chk_bit(nullFlag, 1'b0);
        chk_data(accumulator, 8'hFF);
        step(cise_pkg::OP_NOP, 7'h00, 1'b0, 11'h000, 8'h00);
        chk_data(accumulator, 8'h00);
        chk_bit(nullFlag, 1'b1);
    endtask : test_invert_clear_dec

    task automatic test_skip;
        step(cise_pkg::OP_DECREMENT_FILE, 7'h00, cise_pkg::DEST_ACCUM, 11'h000, 8'h05);
        step(cise_pkg::OP_DECREMENT_SKIP_IF_NULL, 7'h10, cise_pkg::DEST_FILE, 11'h000, 8'h01);
        chk_data(accumulator, 8'h04);
        step(cise_pkg::OP_CLEAR_ACCUMULATOR, 7'h00, 1'b0, 11'h000, 8'h00);
        chk_data(fileWr.data, 8'h00);
        chk_bit(discardNext, 1'b1);
        chk_bit(nullFlag, 1'b0);
        step(cise_pkg::OP_DECREMENT_SKIP_IF_NULL, 7'h00, cise_pkg::DEST_ACCUM, 11'h000, 8'h03);
        chk_data(accumulator, 8'h04);
        chk_bit(discardNext, 1'b0);
        step(cise_pkg::OP_CLEAR_ACCUMULATOR, 7'h00, 1'b0, 11'h000, 8'h00);
        chk_data(accumulator, 8'h02);
        chk_bit(discardNext, 1'b0);
        chk_bit(nullFlag, 1'b0);
        step(cise_pkg::OP_NOP, 7'h00, 1'b0, 11'h000, 8'h00);
        chk_data(accumulator, 8'h00);
    endtask : test_skip

    task automatic test_jump(input logic [4:0] latch, input logic [10:0] lit,
                             input logic [12:0] exp);
        @(posedge clock);
        upperJumpLatch <= latch;
        step(cise_pkg::OP_JUMP_ABSOLUTE, 7'h00, 1'b0, lit, 8'h00);
        step(cise_pkg::OP_INVERT_FILE, 7'h00, cise_pkg::DEST_ACCUM, 11'h000, 8'h00);
        chk_bit(pcLoad, 1'b1);
        chk_pc(pcValue, exp);
        chk_bit(discardNext, 1'b1);
        chk_bit(nullFlag, 1'b1);
        step(cise_pkg::OP_NOP, 7'h00, 1'b0, 11'h000, 8'h00);
        chk_bit(pcLoad, 1'b0);
        chk_data(accumulator, 8'h00);
    endtask : test_jump

    task automatic test_regs;
        reg_write(cise_pkg::REG_ACCUM, 8'h77);
        reg_read(cise_pkg::REG_ACCUM, rdVal);
        chk_data(rdVal, 8'h00);
        reg_read(cise_pkg::REG_STATUS, rdVal);
        chk_data(rdVal, 8'h07);
        reg_write(cise_pkg::REG_CTRL, 8'h00);
        step(cise_pkg::OP_CLEAR_FILE, 7'h05, 1'b0, 11'h000, 8'h44);
        step(cise_pkg::OP_NOP, 7'h00, 1'b0, 11'h000, 8'h00);
        chk_bit(fileWr.en, 1'b0);
        reg_write(cise_pkg::REG_CTRL, 8'h01);
        reg_read(cise_pkg::REG_CTRL, rdVal);
        chk_data(rdVal, 8'h01);
    endtask : test_regs

    // ==========================================================================
    // Main sequence and watchdog
    // ==========================================================================
    initial begin
        clock = 1'b0;
        rst = 1'b1;
        instrIn = '0;
        fileRdData = 8'h00;
        upperJumpLatch = 5'h00;
        watchdogTimeout = 1'b0;
        sleepEnter = 1'b0;
        regAddr = 2'h0;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        miscompares = 0;
        comparisons = 0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        #1;
        test_reset();
        test_kick();
        test_invert_clear_dec();
        test_skip();
        test_jump(5'h18, 11'h7FF, 13'h1FFF);
        test_jump(5'h17, 11'h555, 13'h1555);
        test_regs();
        report_and_stop();
    end

    initial begin
        repeat (2000) @(posedge clock);
        miscompares++;
        report_and_stop();
    end

endmodule : cise_exec_core_tb_top
